/* logic/lowband_map.svh */
// Constants of the lower-band noise shaping, dead-zone and Layer 1 packing stage.
// Assumes Q15 reflection coefficient, Q12 LP coefficients and 16-bit samples.
`ifndef LOWBAND_MAP_SVH
`define LOWBAND_MAP_SVH
`define LB_FRAME_LEN      6'h28
`define LB_LAST_SAMPLE    6'h27
`define LB_BUDGET         7'h50
`define LB_TOP_INDEX      4'h9
`define LB_ETA_LOW        6'h10
`define LB_K1_TILT        16'sh7E00
`define LB_K1_BIAS        18'sh08604
`define LB_GAMMA_NOM      16'h75C3
`define LB_COEF_FRAC      12
`define LB_Q15_FRAC       15
`define LB_AL_OFFSET      16'sh0008
`define LB_MU_OFFSET      16'sh0000
`define LB_MU_DZ_LIM      16'sh0007
`define LB_AL_DZ_LIM      16'sh000B
`define LB_MU_DZ_INDEX    8'hFF
`define LB_AL_DZ_INDEX    8'hD5
`define LB_ALLOC_BOUND    450
`endif

/* logic/lowband_pkg.sv */
// Types shared by the lower-band encoder stage.
// Constants live in lowband_map.svh; this package holds types only.
package lowband_pkg;
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_COEF,
        PH_SAMPLE,
        PH_CORE,
        PH_ALLOC_Q,
        PH_ALLOC_WALK,
        PH_PACK
    } phase_t;
endpackage

/* logic/two_entry_buffer.sv */
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; in_ready and the output side come straight from flops.
`timescale 1ns/10ps
module two_entry_buffer #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    typedef struct packed {
        logic             out_valid;
        logic [WIDTH-1:0] out_data;
        logic             skid_valid;
        logic [WIDTH-1:0] skid_data;
    } buf_state_t;

    buf_state_t st_ff;
    buf_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (st_ff.out_valid && out_ready) begin
            nxt_st.out_valid  = st_ff.skid_valid;
            nxt_st.out_data   = st_ff.skid_data;
            nxt_st.skid_valid = 1'b0;
        end
        // Accept only while the skid slot is free, so a stall loses nothing
        if (in_valid && !st_ff.skid_valid) begin
            if (!nxt_st.out_valid) begin
                nxt_st.out_valid = 1'b1;
                nxt_st.out_data  = in_data;
            end else begin
                nxt_st.skid_valid = 1'b1;
                nxt_st.skid_data  = in_data;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign in_ready  = !st_ff.skid_valid;
    assign out_valid = st_ff.out_valid;
    assign out_data  = st_ff.out_data;
endmodule // two_entry_buffer

/* logic/lowband_deadzone_refinement_mux.sv */
// Lower-band encoder stage: noise feedback, dead-zone quantizer, Layer 1 packing.
// Assumes LP analysis supplies eta, k1 and a1..a4 per frame, and an external
// core PCM encoder answers each core request with a core_ack pulse.
`timescale 1ns/10ps
`include "lowband_map.svh"
module lowband_deadzone_refinement_mux (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // Frame parameters from LP analysis
    input  wire logic               frame_start,
    input  wire logic [5:0]         norm_factor,
    input  wire logic signed [15:0] refl_k1,
    input  wire logic [63:0]        lp_coefs,
    input  wire logic               law_alaw,
    output logic                    frame_ready,
    // Lower-band samples
    input  wire logic               sample_valid,
    input  wire logic signed [15:0] sample_in,
    output logic                    sample_ready,
    // Core PCM encoder
    output logic                    core_req,
    output logic signed [15:0]      core_in,
    input  wire logic               core_ack,
    input  wire logic [2:0]         core_exp,
    input  wire logic [2:0]         core_ref,
    input  wire logic [7:0]         core_index,
    input  wire logic signed [15:0] core_decoded,
    // Per-sample core result
    output logic                    core_code_valid,
    output logic [7:0]              core_code_index,
    output logic                    dead_zone,
    // Layer 1 field, bit serial
    output logic                    refinement_valid,
    output logic                    refinement_code,
    input  wire logic               refinement_ready,
    output logic                    field_end
);
    typedef struct packed {
        lowband_pkg::phase_t phase;
        logic               alaw;
        logic [5:0]         eta;
        logic               low;
        logic               tilt;
        logic [15:0]        gpow;
        logic [15:0]        gamma;
        logic [1:0]         tap;
        logic [3:0][15:0]   a;
        logic [3:0][15:0]   w;
        logic [3:0][15:0]   err;
        logic [5:0]         n;
        logic [9:0][5:0]    cnt;
        logic [39:0][2:0]   exps;
        logic [39:0][3:0]   refs;
        logic [39:0][1:0]   alloc;
        logic [3:0]         j;
        logic [6:0]         budget;
        logic [6:0]         q;
        logic [6:0]         taken;
        logic [1:0]         bitpos;
        logic               push_valid;
        logic               push_bit;
        logic               frame_ready;
        logic               sample_ready;
        logic               core_req;
        logic [15:0]        core_in;
        logic               code_valid;
        logic [7:0]         code_index;
        logic               dz;
        logic               field_end;
    } lb_state_t;

    lb_state_t st_ff;
    lb_state_t nxt_st;
    logic      push_ready;

    function automatic logic [15:0] sat16(input logic signed [35:0] v);
        if (v > 36'sh0_0000_7FFF) begin
            return 16'h7FFF;
        end else if (v < -36'sh0_0000_8000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    // Sample n is listed at index j when j-2 <= exp <= j
    function automatic logic listed(input logic [2:0] e, input logic [3:0] j);
        return ({1'b0, e} <= j) && (({1'b0, e} + 4'h2) >= j);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Noise-shaped input and dead-zone decision

    logic signed [35:0] fb_sum;
    logic signed [15:0] shaped;
    logic signed [15:0] c_off;
    logic signed [16:0] dz_rel;
    logic               in_dz;
    logic [3:0]         dz_ref;
    logic signed [17:0] k1_gap;
    logic [21:0]        alpha;
    logic [37:0]        gamma_wide;

    always_comb begin
        fb_sum = '0;
        for (int t = 0; t < 4; t++) begin
            fb_sum = fb_sum + 36'($signed(st_ff.w[t]) * $signed(st_ff.err[t]));
        end
        c_off  = st_ff.alaw ? `LB_AL_OFFSET : `LB_MU_OFFSET;
        shaped = sat16(36'(sample_in) + (fb_sum >>> `LB_COEF_FRAC) + 36'(c_off));
        dz_rel = 17'(shaped) - 17'(st_ff.alaw ? `LB_AL_OFFSET : 16'sh0000);
        if (st_ff.alaw) begin
            in_dz = st_ff.low && dz_rel >= -17'(`LB_AL_DZ_LIM)
                    && dz_rel <= 17'(`LB_AL_DZ_LIM);
            if (dz_rel <= -17'sh00007) begin
                dz_ref = 4'h0;
            end else if (dz_rel >= 17'sh00007) begin
                dz_ref = 4'h7;
            end else begin
                dz_ref = {1'b0, shaped[3:1]};
            end
        end else begin
            in_dz = st_ff.low && dz_rel >= -17'(`LB_MU_DZ_LIM)
                    && dz_rel <= 17'(`LB_MU_DZ_LIM);
            if (dz_rel <= -17'sh00002) begin
                dz_ref = 4'h0;
            end else if (dz_rel == -17'sh00001) begin
                dz_ref = 4'h2;
            end else if (dz_rel <= 17'sh00001) begin
                dz_ref = 4'h4;
            end else begin
                dz_ref = 4'h8;
            end
        end
        // Tilt gamma; k1 above threshold keeps gamma below one, so no overflow
        k1_gap     = `LB_K1_BIAS - 18'(refl_k1);
        alpha      = 22'(k1_gap) << 4;
        gamma_wide = 38'(alpha) * 38'(`LB_GAMMA_NOM);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    logic               commit;
    logic [2:0]         c_exp;
    logic [3:0]         c_ref;
    logic [7:0]         c_idx;
    logic signed [15:0] c_dec;
    logic signed [15:0] c_sh;
    logic [31:0]        w_prod;
    logic [31:0]        g_prod;
    logic [6:0]         q_take;
    logic [4:0]         shamt;

    always_comb begin
        nxt_st            = st_ff;
        nxt_st.code_valid = 1'b0;
        nxt_st.field_end  = 1'b0;
        commit = 1'b0;
        c_exp  = core_exp;
        c_ref  = {1'b0, core_ref};
        c_idx  = core_index;
        c_dec  = core_decoded;
        c_sh   = $signed(st_ff.core_in);
        w_prod = 32'($signed(st_ff.a[st_ff.tap]) * $signed({1'b0, st_ff.gpow}));
        g_prod = 32'(st_ff.gpow) * 32'(st_ff.gamma);
        shamt  = 5'(st_ff.eta - `LB_ETA_LOW) + 5'(st_ff.tap) + 5'h1;
        q_take = (st_ff.budget < 7'(st_ff.cnt[st_ff.j])) ? st_ff.budget
                                                          : 7'(st_ff.cnt[st_ff.j]);
        case (st_ff.phase)
            lowband_pkg::PH_IDLE: begin
                if (frame_start) begin
                    nxt_st.alaw  = law_alaw;
                    nxt_st.eta   = norm_factor;
                    nxt_st.a     = lp_coefs;
                    nxt_st.low   = norm_factor >= `LB_ETA_LOW;
                    nxt_st.tilt  = norm_factor < `LB_ETA_LOW && refl_k1 > `LB_K1_TILT;
                    nxt_st.gamma = nxt_st.tilt ? gamma_wide[30:15] : `LB_GAMMA_NOM;
                    nxt_st.gpow  = nxt_st.gamma;
                    nxt_st.tap   = 2'h0;
                    nxt_st.n     = '0;
                    nxt_st.cnt   = '0;
                    nxt_st.alloc = '0;
                    nxt_st.phase = lowband_pkg::PH_COEF;
                end
            end
            lowband_pkg::PH_COEF: begin
                if (st_ff.low) begin
                    nxt_st.w[st_ff.tap] = 16'($signed(st_ff.a[st_ff.tap]) >>> shamt);
                end else begin
                    nxt_st.w[st_ff.tap] = w_prod[30:15];
                end
                // One more power of gamma per tap; both factors below one
                nxt_st.gpow = g_prod[30:15];
                nxt_st.tap  = st_ff.tap + 2'h1;
                if (st_ff.tap == 2'h3) begin
                    nxt_st.phase = lowband_pkg::PH_SAMPLE;
                end
            end
            lowband_pkg::PH_SAMPLE: begin
                if (sample_valid) begin
                    c_sh = shaped;
                    if (in_dz) begin
                        commit = 1'b1;
                        c_exp  = 3'h0;
                        c_ref  = dz_ref;
                        c_idx  = st_ff.alaw ? `LB_AL_DZ_INDEX : `LB_MU_DZ_INDEX;
                        c_dec  = 16'sh0000;
                    end else begin
                        nxt_st.core_in = shaped;
                        nxt_st.phase   = lowband_pkg::PH_CORE;
                    end
                    nxt_st.dz = in_dz;
                end
            end
            lowband_pkg::PH_CORE: begin
                commit = core_ack;
            end
            lowband_pkg::PH_ALLOC_Q: begin
                nxt_st.q     = q_take;
                nxt_st.taken = '0;
                nxt_st.n     = '0;
                nxt_st.phase = lowband_pkg::PH_ALLOC_WALK;
            end
            lowband_pkg::PH_ALLOC_WALK: begin
                if (st_ff.taken < st_ff.q && listed(st_ff.exps[st_ff.n], st_ff.j)) begin
                    nxt_st.alloc[st_ff.n] = st_ff.alloc[st_ff.n] + 2'h1;
                    nxt_st.taken          = st_ff.taken + 7'h1;
                end
                nxt_st.n = st_ff.n + 6'h1;
                if (st_ff.n == `LB_LAST_SAMPLE || nxt_st.taken == st_ff.q) begin
                    nxt_st.budget = st_ff.budget - st_ff.q;
                    if (nxt_st.budget == 7'h0 || st_ff.j == 4'h0) begin
                        nxt_st.n      = '0;
                        nxt_st.bitpos = 2'h0;
                        nxt_st.phase  = lowband_pkg::PH_PACK;
                    end else begin
                        nxt_st.j     = st_ff.j - 4'h1;
                        nxt_st.phase = lowband_pkg::PH_ALLOC_Q;
                    end
                end
            end
            lowband_pkg::PH_PACK: begin
                // Hold the offered bit until the buffer takes it
                if (!st_ff.push_valid || push_ready) begin
                    nxt_st.push_valid = 1'b0;
                    if (st_ff.n == `LB_FRAME_LEN) begin
                        nxt_st.field_end = 1'b1;
                        nxt_st.phase     = lowband_pkg::PH_IDLE;
                    end else if (st_ff.alloc[st_ff.n] == 2'h0) begin
                        nxt_st.n = st_ff.n + 6'h1;
                    end else begin
                        nxt_st.push_valid = 1'b1;
                        nxt_st.push_bit   = st_ff.refs[st_ff.n][2'h2 - st_ff.bitpos];
                        if (st_ff.bitpos + 2'h1 == st_ff.alloc[st_ff.n]) begin
                            nxt_st.bitpos = 2'h0;
                            nxt_st.n      = st_ff.n + 6'h1;
                        end else begin
                            nxt_st.bitpos = st_ff.bitpos + 2'h1;
                        end
                    end
                end
            end
            default: begin
                nxt_st.phase = lowband_pkg::PH_IDLE;
            end
        endcase
        if (commit) begin
            nxt_st.exps[st_ff.n] = c_exp;
            nxt_st.refs[st_ff.n] = c_ref;
            nxt_st.code_valid    = 1'b1;
            nxt_st.code_index    = c_idx;
            // Layer 0 error only; refinement bits never enter the loop
            nxt_st.err = {st_ff.err[2:0], sat16(36'(c_dec) - 36'(c_sh))};
            for (int i = 0; i < 3; i++) begin
                nxt_st.cnt[4'(c_exp) + 4'(i)] = nxt_st.cnt[4'(c_exp) + 4'(i)] + 6'h1;
            end
            nxt_st.n = st_ff.n + 6'h1;
            if (st_ff.n == `LB_LAST_SAMPLE) begin
                nxt_st.j      = `LB_TOP_INDEX;
                nxt_st.budget = `LB_BUDGET;
                nxt_st.phase  = lowband_pkg::PH_ALLOC_Q;
            end else begin
                nxt_st.phase = lowband_pkg::PH_SAMPLE;
            end
        end
        nxt_st.frame_ready  = nxt_st.phase == lowband_pkg::PH_IDLE;
        nxt_st.sample_ready = nxt_st.phase == lowband_pkg::PH_SAMPLE;
        nxt_st.core_req     = nxt_st.phase == lowband_pkg::PH_CORE;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    two_entry_buffer #(
        .WIDTH (1)
    ) u_field_buf (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (st_ff.push_valid),
        .in_data   (st_ff.push_bit),
        .in_ready  (push_ready),
        .out_valid (refinement_valid),
        .out_data  (refinement_code),
        .out_ready (refinement_ready)
    );

    assign frame_ready     = st_ff.frame_ready;
    assign sample_ready    = st_ff.sample_ready;
    assign core_req        = st_ff.core_req;
    assign core_in         = st_ff.core_in;
    assign core_code_valid = st_ff.code_valid;
    assign core_code_index = st_ff.code_index;
    assign dead_zone       = st_ff.dz;
    assign field_end       = st_ff.field_end;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    localparam int alloc_bound = `LB_ALLOC_BOUND;
    logic [7:0] bits_sent_ff;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bits_sent_ff <= 8'h00;
        end else if (st_ff.phase == lowband_pkg::PH_IDLE && frame_start) begin
            bits_sent_ff <= 8'h00;
        end else if (st_ff.push_valid && push_ready) begin
            bits_sent_ff <= bits_sent_ff + 8'h01;
        end
    end

    sequence s_frame_load;
        st_ff.phase == lowband_pkg::PH_IDLE && frame_start;
    endsequence
    sequence s_alloc_enter;
        st_ff.phase != lowband_pkg::PH_ALLOC_Q ##1 st_ff.phase == lowband_pkg::PH_ALLOC_Q;
    endsequence

    property p_tilt_flag;
        @(posedge clock) disable iff (reset)
        s_frame_load |=> st_ff.tilt == ($past(refl_k1) > `LB_K1_TILT
                                       && $past(norm_factor) < `LB_ETA_LOW);
    endproperty
    a_tilt_flag: assert property (p_tilt_flag) else $error("tilt flag wrong");

    property p_low_first;
        @(posedge clock) disable iff (reset)
        s_frame_load ##1 st_ff.low |=> st_ff.w[0] == 16'($signed(st_ff.a[0])
                                        >>> (5'(st_ff.eta - `LB_ETA_LOW) + 5'h1));
    endproperty
    a_low_first: assert property (p_low_first) else $error("low level tap wrong");

    property p_dz_bypass;
        @(posedge clock) disable iff (reset)
        (st_ff.phase == lowband_pkg::PH_SAMPLE && sample_valid && in_dz)
            |=> !st_ff.core_req && st_ff.code_valid && st_ff.dz;
    endproperty
    a_dz_bypass: assert property (p_dz_bypass) else $error("dead zone used core");

    property p_mu_index;
        @(posedge clock) disable iff (reset)
        (st_ff.code_valid && st_ff.dz && !st_ff.alaw) |-> st_ff.code_index == 8'hFF;
    endproperty
    a_mu_index: assert property (p_mu_index) else $error("mu dead zone index");

    property p_al_index;
        @(posedge clock) disable iff (reset)
        (st_ff.code_valid && st_ff.dz && st_ff.alaw) |-> st_ff.code_index == 8'hD5;
    endproperty
    a_al_index: assert property (p_al_index) else $error("A dead zone index");

    property p_err_core;
        @(posedge clock) disable iff (reset)
        (st_ff.phase == lowband_pkg::PH_CORE && core_ack)
            |=> st_ff.err[0] == sat16(36'($past(core_decoded)) - 36'($past(core_in)))
                && st_ff.err[1] == $past(st_ff.err[0]);
    endproperty
    a_err_core: assert property (p_err_core) else $error("core error feedback");

    property p_err_hold;
        @(posedge clock) disable iff (reset)
        !st_ff.code_valid |-> $stable(st_ff.err);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error moved early");

    property p_field_bits;
        @(posedge clock) disable iff (reset)
        st_ff.field_end |-> bits_sent_ff == 8'h50;
    endproperty
    a_field_bits: assert property (p_field_bits) else $error("field not 80 bits");

    property p_alloc_ends;
        @(posedge clock) disable iff (reset)
        s_alloc_enter |-> ##[1:alloc_bound] st_ff.phase == lowband_pkg::PH_PACK;
    endproperty
    a_alloc_ends: assert property (p_alloc_ends) else $error("allocation hung");
endmodule // lowband_deadzone_refinement_mux

/* verification/core_partner.sv */
// Partner model: core PCM encoder and Layer 1 bit sink.
// Assumes core_req stays up until it sees core_ack; answers fast or slow.
`timescale 1ns/10ps
module core_partner (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // Core request and answer
    input  wire logic               core_req,
    input  wire logic signed [15:0] core_in,
    output logic                    core_ack,
    output logic [2:0]              core_exp,
    output logic [2:0]              core_ref,
    output logic [7:0]              core_index,
    output logic signed [15:0]      core_decoded,
    // Layer 1 sink
    output logic                    refinement_ready
);
    logic [3:0] tick_ff;
    logic [1:0] wait_ff;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {tick_ff, wait_ff, core_ack, refinement_ready} <= '0;
            {core_exp, core_ref, core_index, core_decoded} <= '0;
        end else begin
            tick_ff <= tick_ff + 4'h1;
            // Four-cycle stalls every eight keep the buffer busy
            refinement_ready <= ~tick_ff[2];
            core_ack <= 1'b0;
            // Answer lines carry junk outside the acknowledge cycle
            {core_exp, core_ref} <= {~tick_ff[2:0], tick_ff[2:0]};
            core_index <= {2{tick_ff}};
            core_decoded <= {4{~tick_ff}};
            wait_ff <= core_req ? wait_ff + 2'h1 : 2'h0;
            if (core_req && !core_ack && wait_ff == (tick_ff[3] ? 2'h3 : 2'h0)) begin
                core_ack <= 1'b1;
                wait_ff <= 2'h0;
                {core_exp, core_ref} <= {core_in[6:4], core_in[3:1]};
                core_index <= core_in[7:0] ^ 8'h55;
                core_decoded <= core_in | 16'sh0002;
            end
        end
    end
endmodule // core_partner

/* verification/tb_top.sv */
// Self-checking bench for the lower-band shaping and Layer 1 stage.
// Assumes core_partner stands on the core and Layer 1 side.
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic signed [15:0] s;
        logic [3:0]         mu;
        logic [3:0]         al;
    } row_t;
    // Refinement per law; 4'hF means core path
    row_t rows [10] = '{'{-16'sh0007, 4'h0, 4'h0}, '{-16'sh0002, 4'h0, 4'h3},
        '{-16'sh0001, 4'h2, 4'h3}, '{16'sh0001, 4'h4, 4'h4}, '{16'sh0002, 4'h8, 4'h5},
        '{16'sh0007, 4'h8, 4'h7}, '{16'sh0000, 4'h4, 4'h4}, '{16'sh000A, 4'hF, 4'h7},
        '{-16'sh000A, 4'hF, 4'h0}, '{16'sh0066, 4'hF, 4'hF}};
    logic                clock = 1'b0;
    logic                reset, frame_start, law_alaw, sample_valid;
    logic [5:0]          norm_factor;
    logic signed [15:0]  refl_k1, sample_in, core_in, core_decoded;
    logic [63:0]         lp_coefs;
    logic                frame_ready, sample_ready, core_req, core_ack, core_code_valid;
    logic                dead_zone, refinement_valid, refinement_code, refinement_ready;
    logic                field_end;
    logic [2:0]          core_exp, core_ref;
    logic [7:0]          core_index, core_code_index;
    logic signed [15:0]  sv [40], shv [40];
    logic                dzv [40];
    logic [3:0]          refv [40];
    logic                exp_q [$];
    int                  errors = 0, checks_done = 0, ends = 0;
    real                 gam;
    ////////////////////////////////////////
    always #5 clock = ~clock;
    lowband_deadzone_refinement_mux uut (.clock, .reset, .frame_start, .norm_factor,
        .refl_k1, .lp_coefs, .law_alaw, .frame_ready, .sample_valid, .sample_in,
        .sample_ready, .core_req, .core_in, .core_ack, .core_exp, .core_ref, .core_index,
        .core_decoded, .core_code_valid, .core_code_index, .dead_zone, .refinement_valid,
        .refinement_code, .refinement_ready, .field_end);
    core_partner partner (.clock, .reset, .core_req, .core_in, .core_ack, .core_exp,
        .core_ref, .core_index, .core_decoded, .refinement_ready);
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    task automatic wrap_up;
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic fill_rows(input logic alaw, input logic [5:0] eta);
        row_t r;
        for (int n = 0; n < 40; n++) begin
            r = rows[n % 10];
            sv[n] = r.s;
            shv[n] = r.s + (alaw ? 16'sh0008 : 16'sh0000);
            dzv[n] = (alaw ? r.al : r.mu) != 4'hF && eta >= 6'h10;
            refv[n] = dzv[n] ? (alaw ? r.al : r.mu) : {1'b0, shv[n][3:1]};
        end
    endtask
    // Expected Layer 1 stream, built before the frame runs
    task automatic build_bits;
        int ba [40];
        int e [40];
        int bud, t;
        logic [2:0] code;
        bud = 80;
        for (int n = 0; n < 40; n++) begin
            ba[n] = 0;
            e[n] = dzv[n] ? 0 : int'(shv[n][6:4]);
        end
        for (int j = 9; j >= 0 && bud > 0; j--) begin
            t = 0;
            for (int n = 0; n < 40; n++) begin
                if (t < bud && e[n] <= j && e[n] + 2 >= j) begin
                    ba[n]++;
                    t++;
                end
            end
            bud -= t;
        end
        for (int n = 0; n < 40; n++) begin
            code = refv[n][2:0] >> (3 - ba[n]);
            for (int b = ba[n] - 1; b >= 0; b--) exp_q.push_back(code[b]);
        end
    endtask
    task automatic run_frame(input logic [5:0] eta, input logic [15:0] k1,
                             input logic [63:0] coefs, input logic alaw);
        int w;
        build_bits();
        {frame_start, norm_factor, refl_k1, lp_coefs, law_alaw} <= {1'b1, eta, k1, coefs, alaw};
        do @(posedge clock); while (frame_ready !== 1'b1);
        frame_start <= 1'b0;
        for (int n = 0; n < 40; n++) begin
            sample_in <= sv[n];
            sample_valid <= 1'b1;
            do @(posedge clock); while (sample_ready !== 1'b1);
            sample_valid <= 1'b0;
            for (w = 0; w < 40; w++) begin
                @(posedge clock);
                if (core_req === 1'b1) chk(core_in, shv[n], "shaped input");
                if (core_code_valid === 1'b1) break;
            end
            chk(16'(w < 40), 16'h0001, "no result");
            chk(core_code_index, dzv[n] ? (alaw ? 8'hD5 : 8'hFF) : shv[n][7:0] ^ 8'h55,
                "core index");
            chk(dead_zone, dzv[n], "dead zone");
        end
        for (w = 0; w < 900 && exp_q.size() > 0; w++) @(posedge clock);
        chk(16'(exp_q.size()), 16'h0000, "bits missing");
    endtask
    ////////////////////////////////////////
    always @(posedge clock) begin
        if (refinement_valid === 1'b1 && refinement_ready === 1'b1) begin
            if (exp_q.size() == 0) chk(16'h0001, 16'h0000, "extra bit");
            else chk(refinement_code, exp_q.pop_front(), "layer 1 bit");
        end
        // At most the two buffered bits may still be on their way
        if (field_end === 1'b1) begin
            ends++;
            chk(16'(exp_q.size() > 2), 16'h0000, "field end early");
        end
    end
    initial begin
        {reset, frame_start, law_alaw, sample_valid} = 4'h8;
        {norm_factor, refl_k1, sample_in, lp_coefs} = '0;
        repeat (16) @(posedge clock);
        chk({frame_ready, sample_ready, core_req, refinement_valid}, 16'h0000, "reset out");
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        chk(frame_ready, 16'h0001, "idle ready");
        fill_rows(1'b1, 6'h10);
        run_frame(6'h10, 16'h0000, 64'h0, 1'b1);
        // Mu-law frame ends with zero errors so the next frame starts clean
        fill_rows(1'b0, 6'h10);
        run_frame(6'h10, 16'h0000, 64'h0, 1'b0);
        // Low level, so no tilt despite k1 above threshold: only the halved first tap may act
        for (int n = 0; n < 40; n++) begin
            sv[n] = n == 0 ? 16'sh0014 : n == 1 ? 16'sh001E : 16'sh0000;
            shv[n] = n == 1 ? 16'sh001F : sv[n];
            dzv[n] = n > 1;
            refv[n] = n > 1 ? 4'h4 : {1'b0, shv[n][3:1]};
        end
        run_frame(6'h10, 16'h7F00, 64'h1000, 1'b0);
        // Tilted frame above low level: a1 of seven, fed-back error of two
        fill_rows(1'b0, 6'h0F);
        gam = 0.92 * 16.0 * (1.047 - 32512.0 / 32768.0);
        for (int n = 1; n < 40; n++) begin
            shv[n] = sv[n] + (shv[n - 1][1] ? 16'sh0000 : 16'($rtoi(gam * 14.0)));
            refv[n] = {1'b0, shv[n][3:1]};
        end
        run_frame(6'h0F, 16'h7F00, 64'h7000, 1'b0);
        chk(16'(ends), 16'h0004, "field ends");
        wrap_up();
    end
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule // tb_top
